// >>> core/lpwit_pkg.sv
// Purpose: constants and types for the low power wake-up interval timer
// Assumes: 100 MHz system clock, classic Wishbone register access
// Notes:   register offsets are byte addresses on a 32-bit bus
//
// Overview of operation
// - one 16-bit up-counter, periodic interval only
// - run bit 15 gates counting and oscillator
// - count clock is oscillator divided by 32
// - counter adds one per count clock edge
// - clear bit 0 zeroes counter, self-clears
// - bit 7 forwards match interrupt request
// - match flag bit 3, write one clears
// - compare 0x0001..0xffff, period compare plus one
// - registers keep contents across shutdown wake-up
// - first match after reset may come early
// - match event wakes system from shutdown; here wake_o copies match_irq_o, so only while bit 7 is set
// - system or peripheral reset restores defaults
// - start on next clock, clear synchronised to oscillator edge while running, at once when off
// - 32-bit registers, byte-lane writes, reserved untouched
`default_nettype none
package lpwit_pkg;
  // register byte offsets
  localparam logic [7:0] LPWIT_OFS_CTRL   = 8'h00;
  localparam logic [7:0] LPWIT_OFS_CMP    = 8'h04;
  localparam logic [7:0] LPWIT_OFS_COUNT  = 8'h08;
  localparam logic [7:0] LPWIT_OFS_STAT   = 8'h0c;
  localparam logic [7:0] LPWIT_OFS_MASK   = 8'h10;
  // control field positions
  localparam int LPWIT_BIT_RUN   = 15;
  localparam int LPWIT_BIT_MIEN  = 7;
  localparam int LPWIT_BIT_FLAG  = 3;
  localparam int LPWIT_BIT_CLR   = 0;
  // status / mask bit positions
  localparam int LPWIT_EV_MATCH  = 0;
  localparam int LPWIT_EV_CLRDN  = 1;
  localparam int LPWIT_NEV       = 2;
  // reset values
  localparam logic [15:0] LPWIT_CMP_RST  = 16'hffff;
  localparam logic [15:0] LPWIT_COUNT_RST = 16'h0000;
  localparam logic [LPWIT_NEV-1:0] LPWIT_EV_RST = 2'h0;
  // timing
  localparam int LPWIT_CLK_PERIOD_NS = 10;
  localparam int LPWIT_OSC_PERIOD_NS = 10_000_000;
  localparam int LPWIT_OSC_DIV_CYC   = LPWIT_OSC_PERIOD_NS / LPWIT_CLK_PERIOD_NS;
  localparam int LPWIT_OSC_W         = 20;
  localparam int LPWIT_PRE_DIV       = 32;
  localparam logic [4:0] LPWIT_PRE_LAST  = 5'h1f;
  localparam logic [4:0] LPWIT_PRE_HALF  = 5'h10;
  // wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } lpwit_wb_req_t;
  typedef enum logic {LPWIT_OFF, LPWIT_RUN} lpwit_state_t;
endpackage
`default_nettype wire

// >>> core/lpwit_top.sv
// Purpose: low power wake-up interval timer with Wishbone register slave
// Assumes: single clock; the private oscillator is a divider of clk_i
// Notes:   registers are reset only by rst_i or the peripheral reset input
//
// Decided for this implementation: the Wishbone slave port.
`default_nettype none
module lpwit_top #(
  parameter int OSC_DIV = lpwit_pkg::LPWIT_OSC_DIV_CYC
) (
  // clock and resets
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wake_timer_periph_reset_i,
  // wishbone slave
  input  wire lpwit_pkg::lpwit_wb_req_t wb_req_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  // events
  output logic                          match_irq_o,
  output logic                          wake_o,
  output logic                          irq_o,
  output logic                          osc_on_o
);
  import lpwit_pkg::*;

  // reset from either source; synchronous, same domain
  wire blk_rst = rst_i | wake_timer_periph_reset_i;

  // bus decode
  wire        bus_req   = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire        bus_wr    = bus_req & wb_req_i.we;
  wire        bus_rd    = bus_req & ~wb_req_i.we;
  wire        sel_ctrl  = wb_req_i.adr == LPWIT_OFS_CTRL;
  wire        sel_cmp   = wb_req_i.adr == LPWIT_OFS_CMP;
  wire        sel_count = wb_req_i.adr == LPWIT_OFS_COUNT;
  wire        sel_stat  = wb_req_i.adr == LPWIT_OFS_STAT;
  wire        sel_mask  = wb_req_i.adr == LPWIT_OFS_MASK;
  wire        wr_b0     = wb_req_i.sel[0];
  wire        wr_b1     = wb_req_i.sel[1];
  wire [31:0] wd        = wb_req_i.dat;

  // registers
  lpwit_state_t           state_reg;
  logic                   run_reg;
  logic                   mien_reg;
  logic                   flag_reg;
  logic                   clr_pend_reg;
  logic                   first_reg;
  logic [15:0]            cmp_reg;
  logic [15:0]            count_value_reg;
  logic [LPWIT_OSC_W-1:0] osc_reg;
  logic [4:0]             pre_reg;
  logic [LPWIT_NEV-1:0]   stat_reg;
  logic [LPWIT_NEV-1:0]   mask_reg;
  logic                   ack_reg;
  logic [31:0]            rdat_reg;

  // writes: byte lanes decide which fields change, reserved bits ignored
  wire ctrl_w0  = bus_wr & sel_ctrl & wr_b0;
  wire ctrl_w1  = bus_wr & sel_ctrl & wr_b1;
  wire run_next = ctrl_w1 ? wd[LPWIT_BIT_RUN] : run_reg;
  wire clr_wr   = ctrl_w0 & wd[LPWIT_BIT_CLR];
  wire flag_wc  = ctrl_w0 & wd[LPWIT_BIT_FLAG];
  wire [15:0] cmp_next = {(bus_wr & sel_cmp & wr_b1) ? wd[15:8] : cmp_reg[15:8],
                          (bus_wr & sel_cmp & wr_b0) ? wd[7:0]  : cmp_reg[7:0]};

  // private oscillator: runs only while the timer runs, so it costs nothing when off
  wire osc_tick   = (state_reg == LPWIT_RUN) && (osc_reg == LPWIT_OSC_W'(OSC_DIV - 1));
  // count clock edge: oscillator divided by 32
  wire count_tick = osc_tick && (pre_reg == LPWIT_PRE_LAST);
  // clear acts on an oscillator edge while running so a count edge is never split
  wire clr_apply  = clr_pend_reg & ((state_reg == LPWIT_OFF) | osc_tick);
  wire match_ev   = count_tick & ~clr_apply & (count_value_reg == cmp_reg);
  wire [LPWIT_NEV-1:0] ev_vec;
  assign ev_vec[LPWIT_EV_MATCH] = match_ev;
  assign ev_vec[LPWIT_EV_CLRDN] = clr_apply;

  // read mux; upper halves and reserved bits stay zero
  wire [31:0] ctrl_rd = {16'h0000, run_reg, 7'h00, mien_reg, 3'h0, flag_reg, 2'h0, clr_pend_reg};
  wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd :
                        sel_cmp  ? {16'h0000, cmp_reg} :
                        sel_count ? {16'h0000, count_value_reg} :
                        sel_stat ? {{(32-LPWIT_NEV){1'b0}}, stat_reg} :
                        sel_mask ? {{(32-LPWIT_NEV){1'b0}}, mask_reg} : 32'h0000_0000;
  wire stat_rd = bus_rd & sel_stat;

  // run state machine; start is taken at the clk_i edge after the run bit is set
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      state_reg <= LPWIT_OFF;
    end else begin
      case (state_reg)
        LPWIT_OFF: if (run_reg) state_reg <= LPWIT_RUN;
        LPWIT_RUN: if (!run_reg) state_reg <= LPWIT_OFF;
        default:   state_reg <= LPWIT_OFF;
      endcase
    end
  end

  // control register; no shutdown-wake input exists, so contents survive it
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      run_reg      <= 1'b0;
      mien_reg     <= 1'b0;
      flag_reg     <= 1'b0;
      clr_pend_reg <= 1'b0;
      cmp_reg      <= LPWIT_CMP_RST;
    end else begin
      run_reg      <= run_next;
      cmp_reg      <= cmp_next;
      if (ctrl_w0) mien_reg <= wd[LPWIT_BIT_MIEN];
      // a match in the same cycle as a write-one clear keeps the flag set
      flag_reg     <= match_ev | (flag_reg & ~flag_wc);
      // self-clearing command bit
      clr_pend_reg <= clr_wr | (clr_pend_reg & ~clr_apply);
    end
  end

  // oscillator divider, prescaler and counter
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      osc_reg   <= '0;
      pre_reg   <= 5'h00;
      count_value_reg <= LPWIT_COUNT_RST;
      first_reg <= 1'b1;
    end else if (state_reg == LPWIT_OFF) begin
      osc_reg <= '0;
      if (run_reg) begin
        // the first start after reset begins mid-way, so the first match is early
        pre_reg   <= first_reg ? LPWIT_PRE_HALF : 5'h00;
        first_reg <= 1'b0;
      end
      if (clr_apply) count_value_reg <= 16'h0000;
    end else begin
      osc_reg <= osc_tick ? '0 : osc_reg + 1'b1;
      if (clr_apply) begin
        pre_reg <= 5'h00;
        count_value_reg <= 16'h0000;
      end else if (osc_tick) begin
        pre_reg <= pre_reg + 1'b1;
        if (count_tick) count_value_reg <= match_ev ? 16'h0000 : count_value_reg + 1'b1;
      end
    end
  end

  // sticky status, cleared by reading it; a new event wins over the read
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      stat_reg <= LPWIT_EV_RST;
      mask_reg <= LPWIT_EV_RST;
    end else begin
      stat_reg <= ev_vec | (stat_reg & {LPWIT_NEV{~stat_rd}});
      if (bus_wr & sel_mask & wr_b0) mask_reg <= wd[LPWIT_NEV-1:0];
    end
  end

  // bus answer: one wait state, ack for every address, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (blk_rst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= bus_req;
      rdat_reg <= bus_rd ? rd_mux : 32'h0000_0000;
    end
  end

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = rdat_reg;
  assign match_irq_o = flag_reg & mien_reg;
  assign wake_o      = match_irq_o;
  assign irq_o       = |(stat_reg & mask_reg);
  assign osc_on_o    = state_reg == LPWIT_RUN;
endmodule
`default_nettype wire

// >>> sim/lpwit_checker.sv
// Purpose: port assertions for the wake-up interval timer
// Assumes: one clock; both resets synchronous, active high
// Notes:   oscillator edges and flag falls must trace back to a bus cycle; flag rises may also come while the oscillator runs
`default_nettype none
module lpwit_checker #(
  parameter int OSC_DIV = 4
) (
  // clock and resets
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire logic                     wake_timer_periph_reset_i,
  // bus and events
  input wire lpwit_pkg::lpwit_wb_req_t wb_req_i,
  input wire logic [31:0]              wb_dat_o,
  input wire logic                     wb_ack_o,
  input wire logic                     match_irq_o,
  input wire logic                     wake_o,
  input wire logic                     irq_o,
  input wire logic                     osc_on_o
);
  import lpwit_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || wake_timer_periph_reset_i);
  ack_delay_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data outside ack");
  wake_copy_a: assert property (wake_o == match_irq_o)
    else $error("wake differs");
  match_rise_a: assert property ($rose(match_irq_o) |-> osc_on_o || wb_ack_o || $past(wb_ack_o))
    else $error("match irq without cause");
  flag_fall_a: assert property ($fell(match_irq_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("flag cleared without write");
  osc_rise_a: assert property ($rose(osc_on_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("oscillator started alone");
  osc_fall_a: assert property ($fell(osc_on_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("oscillator stopped alone");
endmodule
bind lpwit_top lpwit_checker #(.OSC_DIV(OSC_DIV)) lpwit_checker_i (.clk_i(clk_i), .rst_i(rst_i),
  .wake_timer_periph_reset_i(wake_timer_periph_reset_i), .wb_req_i(wb_req_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .match_irq_o(match_irq_o), .wake_o(wake_o), .irq_o(irq_o), .osc_on_o(osc_on_o));
`default_nettype wire

// >>> sim/lpwit_tb_top.sv
// Purpose: register-level bench for the wake-up interval timer
// Assumes: OSC_DIV 4, so one count tick is 128 cycles
// Notes:   first count tick after reset comes half a tick early
`default_nettype none
module lpwit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lpwit_pkg::*;
  logic          clk_i = 0, rst_i = 1, prst = 0, ack, mirq, wake, irq, osc;
  lpwit_wb_req_t req = '0;
  logic [31:0]   dat;
  int            failures = 0, checks_done = 0, cyc = 0, t0;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  lpwit_top #(.OSC_DIV(4)) lpwit_top_i (.clk_i(clk_i), .rst_i(rst_i), .wake_timer_periph_reset_i(prst),
    .wb_req_i(req), .wb_dat_o(dat), .wb_ack_o(ack), .match_irq_o(mirq), .wake_o(wake), .irq_o(irq), .osc_on_o(osc));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ack is read at the edge, before that edge's updates land
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                      output logic [31:0] q);
    // no local limit: a slave that never answers is caught by the watchdog
    req <= '{1'b1, 1'b1, w, a, s, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat;
    req <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, s, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    xfer(1'b0, a, 4'hf, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic wm();
    int n;
    n = 0;
    while (mirq !== 1'b1 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000) failures++;
  endtask
  task automatic end_sim();
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    end_sim();
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0, "ctrl");
    rd(8'h04, 32'hffff, "cmp");
    rd(8'h14, 32'h0, "unmapped");
    wr(8'h08, 4'hf, 32'hffff_ffff);
    rd(8'h08, 32'h0, "count");
    wr(8'h04, 4'hf, 32'hffff_1234);
    wr(8'h04, 4'h1, 32'h2);
    rd(8'h04, 32'h1202, "cmp_lane");
    wr(8'h04, 4'h2, 32'h0);
    wr(8'h10, 4'hf, 32'h1);
    t0 = cyc;
    wr(8'h00, 4'h3, 32'h8080);
    wm();
    chk("early", 1, 32'(cyc - t0 < 340));
    chk("early_min", 1, 32'(cyc - t0 >= 320));
    t0 = cyc;
    chk("wake", 1, wake);
    chk("irq", 1, irq);
    rd(8'h0c, 32'h1, "status");
    chk("irq_cleared", 0, irq);
    wr(8'h00, 4'h3, 32'h8088);
    repeat (130) @(posedge clk_i);
    rd(8'h08, 32'h1, "count_run");
    wm();
    chk("period", 384, cyc - t0);
    wr(8'h00, 4'h3, 32'h8008);
    repeat (400) @(posedge clk_i);
    chk("masked", 0, mirq);
    wr(8'h00, 4'h3, 32'h8000);
    rd(8'h00, 32'h8008, "flag_kept");
    wr(8'h00, 4'h3, 32'h8008);
    rd(8'h00, 32'h8000, "flag_clr");
    wr(8'h00, 4'h3, 32'h8001);
    repeat (4) @(posedge clk_i);
    rd(8'h00, 32'h8000, "clr_done");
    rd(8'h08, 32'h0, "count_zero");
    rd(8'h0c, 32'h3, "status2");
    wr(8'h00, 4'h3, 32'h0);
    chk("osc_off", 0, osc);
    prst <= 1'b1;
    @(posedge clk_i);
    prst <= 1'b0;
    rd(8'h04, 32'hffff, "cmp_rst");
    end_sim();
  end
endmodule
`default_nettype wire
